// [uedma_defs.svh]
// constants of the endpoint dma slave port: offsets, field positions,
// reset values and counts; included by the design files and the bench
`ifndef UEDMA_DEFS_SVH
`define UEDMA_DEFS_SVH
// register byte offsets
`define UEDMA_A_CFG 8'h00
`define UEDMA_A_CNT 8'h04
`define UEDMA_A_HW 8'h08
`define UEDMA_A_STAT 8'h0c
`define UEDMA_A_REM 8'h10
`define UEDMA_A_EP_BASE 8'h40
// transfer_config_register fields
`define UEDMA_CFG_EN 0
`define UEDMA_CFG_COUNTER_TERMINATION_ENABLE 1
`define UEDMA_CFG_SHORT_PACKET_TERMINATION_ENABLE 2
`define UEDMA_CFG_BURST 3
`define UEDMA_CFG_IDX_LSB 4
`define UEDMA_CFG_RST 8'h00
// hardware_config_register fields
`define UEDMA_HW_ACKONLY 0
`define UEDMA_HW_REQHI 1
`define UEDMA_HW_ACKHI 2
`define UEDMA_HW_RST 3'h6
// endpoint_config_register fields
`define UEDMA_EP_DIR 0
`define UEDMA_EP_ISO 1
`define UEDMA_EP_ENA 2
`define UEDMA_EP_RST 3'h0
`define UEDMA_EP0_CFG 3'h4
// status fields
`define UEDMA_ST_BUSY 0
`define UEDMA_ST_EOT 1
`define UEDMA_ST_REQ 2
// counts
`define UEDMA_CNT_RST 16'h0000
`define UEDMA_WORD_BYTES 16'h0002
`define UEDMA_BURST_BYTES 16
`define UEDMA_BURST_WORDS 3'h7
`define UEDMA_IDX_MIN 4'h2
`endif

// [uedma_pkg.sv]
// types shared by the endpoint dma slave port
// assumes uedma_defs.svh sits in the include path
package uedma_pkg;
  typedef enum logic [1:0] {
    UEDMA_OFF,
    UEDMA_ARMED,
    UEDMA_REQ,
    UEDMA_DONE
  } uedma_state_t;
  typedef logic [3:0] uedma_idx_t;
endpackage : uedma_pkg

// [uedma_ep_cfg_mem.sv]
// per-endpoint configuration store, two registered read ports
// assumes one clock; clear comes from usb bus reset only
`timescale 1ns/100ps
`include "uedma_defs.svh"
module uedma_ep_cfg_mem
  import uedma_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic we,
  input wire uedma_idx_t waddr,
  input wire logic [2:0] wdata,
  input wire uedma_idx_t raddr_a,
  output logic [2:0] rdata_a,
  input wire uedma_idx_t raddr_b,
  output logic [2:0] rdata_b
);
  logic [2:0] mem_q [16];

  // control endpoint is fixed, never stored
  function automatic logic [2:0] rd_word(input uedma_idx_t a, input logic [2:0] v);
    rd_word = (a == 4'h0) ? `UEDMA_EP0_CFG : v;
  endfunction : rd_word

  // storage; clear wins over a same-cycle write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++) mem_q[i] <= `UEDMA_EP_RST;
    end else if (clear) begin
      for (int i = 0; i < 16; i++) mem_q[i] <= `UEDMA_EP_RST;
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // registered read ports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_a <= `UEDMA_EP_RST;
      rdata_b <= `UEDMA_EP_RST;
    end else begin
      rdata_a <= rd_word(raddr_a, mem_q[raddr_a]);
      rdata_b <= rd_word(raddr_b, mem_q[raddr_b]);
    end
  end
endmodule : uedma_ep_cfg_mem

// [uedma_top.sv]
// endpoint dma slave port with ahb-lite register slave
// assumes strobes, ack and end inputs are synchronous to hclk and that the
// endpoint buffer shows the next word of buf_ep_sel on buf_rdata
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`include "uedma_defs.svh"
module uedma_top
  import uedma_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic transfer_request_out,
  input wire logic transfer_ack_in,
  input wire logic end_of_transfer_in,
  input wire logic rd_strobe_in,
  input wire logic wr_strobe_in,
  input wire logic [15:0] dma_data_in,
  output logic [15:0] dma_data_out,
  output logic dma_data_oe,
  input wire logic usb_bus_reset,
  input wire logic [15:0] ep_packet_ready,
  input wire logic buf_short_last,
  input wire logic usb_eop,
  input wire uedma_idx_t pio_ep_sel,
  input wire logic [15:0] buf_rdata,
  output uedma_idx_t buf_ep_sel,
  output logic buf_rd,
  output logic buf_wr,
  output logic [15:0] buf_wdata,
  output logic buf_validate,
  output logic eot_pulse
);
  uedma_state_t st_q;
  logic [7:0] cfg_q;
  logic [15:0] cnt_reg_q;
  logic [15:0] cnt_q;
  logic [2:0] hw_q;
  logic [2:0] burst_q;
  logic eot_flag_q;
  logic req_act_q;
  logic rd_prev_q;
  logic wr_prev_q;
  logic ack_prev_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr_q;
  logic [2:0] ep_sw_rdata;
  logic [2:0] ep_dma_cfg;

  // saturating two-byte step of the transfer counter
  function automatic logic [15:0] step_cnt(input logic [15:0] c);
    step_cnt = (c > `UEDMA_WORD_BYTES) ? c - `UEDMA_WORD_BYTES : 16'h0000;
  endfunction : step_cnt

  // endpoint config words live at base plus four times endpoint
  function automatic logic is_ep_addr(input logic [7:0] a);
    is_ep_addr = (a[7:6] == 2'(`UEDMA_A_EP_BASE >> 6)) && (a[1:0] == 2'h0);
  endfunction : is_ep_addr

  // derived controls
  logic ack_act;
  logic idx_ok;
  uedma_idx_t dma_idx;
  uedma_idx_t dma_ep;
  logic ep_dir;
  logic ep_iso;
  logic ep_ena;
  logic st_act;
  logic word_done;
  logic [15:0] cnt_next;
  logic cnt_hit;
  logic short_out_hit;
  logic short_in_hit;
  logic eot_hit;
  logic can_req;
  logic cfg_wr;
  logic start;
  logic burst_end;

  assign dma_idx = cfg_q[`UEDMA_CFG_IDX_LSB +: 4];
  assign idx_ok = dma_idx >= `UEDMA_IDX_MIN;
  assign dma_ep = dma_idx - 4'h1; // code minus one is the endpoint
  assign ep_dir = ep_dma_cfg[`UEDMA_EP_DIR];
  assign ep_iso = ep_dma_cfg[`UEDMA_EP_ISO];
  assign ep_ena = ep_dma_cfg[`UEDMA_EP_ENA];
  // ack polarity follows the hardware config
  assign ack_act = transfer_ack_in ~^ hw_q[`UEDMA_HW_ACKHI];
  assign st_act = (st_q == UEDMA_ARMED) || (st_q == UEDMA_REQ);
  // out endpoint: word ends with read strobe; in: taken at write strobe
  assign word_done = st_act && idx_ok &&
    (ep_dir ? (ack_act && wr_strobe_in && !wr_prev_q)
            : (ack_prev_q && rd_prev_q && !rd_strobe_in));
  assign cnt_next = step_cnt(cnt_q);
  assign cnt_hit = word_done && cfg_q[`UEDMA_CFG_COUNTER_TERMINATION_ENABLE] && (cnt_next == 16'h0000);
  assign short_out_hit = word_done && cfg_q[`UEDMA_CFG_SHORT_PACKET_TERMINATION_ENABLE] && !ep_dir && !ep_iso &&
    buf_short_last;
  assign short_in_hit = word_done && cfg_q[`UEDMA_CFG_SHORT_PACKET_TERMINATION_ENABLE] && ep_dir && !ep_iso &&
    (cnt_next == 16'h0000);
  // iso also ends on end-of-packet; the controller may end any transfer
  assign eot_hit = cnt_hit || short_out_hit || short_in_hit ||
    (st_act && ep_iso && usb_eop) || (st_act && ack_act && end_of_transfer_in);
  // no new request while the previous ack is still up
  assign can_req = idx_ok && ep_ena && ep_packet_ready[dma_ep] && !ack_act &&
    !hw_q[`UEDMA_HW_ACKONLY];
  assign cfg_wr = wr_pend_q && (wr_addr_q == `UEDMA_A_CFG);
  assign start = cfg_wr && hwdata[`UEDMA_CFG_EN] &&
    ((st_q == UEDMA_OFF) || (st_q == UEDMA_DONE));
  // burst holds for at most 16 bytes, single drops after each word
  assign burst_end = !cfg_q[`UEDMA_CFG_BURST] || (burst_q == `UEDMA_BURST_WORDS);

  uedma_ep_cfg_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(usb_bus_reset),
    .we(wr_pend_q && is_ep_addr(wr_addr_q) && (wr_addr_q[5:2] != 4'h0)),
    .waddr(wr_addr_q[5:2]),
    .wdata(hwdata[2:0]),
    .raddr_a(haddr[5:2]),
    .rdata_a(ep_sw_rdata),
    .raddr_b(dma_ep),
    .rdata_b(ep_dma_cfg)
  );

  // ahb-lite address phase capture; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      rd_pend_q <= hsel && htrans[1] && !hwrite;
      wr_addr_q <= haddr[7:0];
      rd_addr_q <= haddr[7:0];
    end else begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
  end

  // read data and ready; ready drops in the first read data cycle so the
  // answer can come from a register; unmapped reads give zero, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
      hrdata <= 32'h0000_0000;
      if (rd_pend_q) begin
        unique case (rd_addr_q)
          `UEDMA_A_CFG: hrdata <= {24'h000000, cfg_q};
          `UEDMA_A_CNT: hrdata <= {16'h0000, cnt_reg_q};
          `UEDMA_A_HW: hrdata <= {29'h00000000, hw_q};
          `UEDMA_A_STAT: hrdata <= {29'h00000000, req_act_q, eot_flag_q, st_act};
          `UEDMA_A_REM: hrdata <= {16'h0000, cnt_q};
          default: hrdata <= is_ep_addr(rd_addr_q) ? {29'h00000000, ep_sw_rdata} : 32'h0;
        endcase
      end
    end
  end

  // software registers; bus reset clears the transfer config and count, the hardware config keeps its value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= `UEDMA_CFG_RST;
      cnt_reg_q <= `UEDMA_CNT_RST;
      hw_q <= `UEDMA_HW_RST;
    end else if (usb_bus_reset) begin
      cfg_q <= `UEDMA_CFG_RST;
      cnt_reg_q <= `UEDMA_CNT_RST;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `UEDMA_A_CFG) cfg_q <= hwdata[7:0];
      if (wr_addr_q == `UEDMA_A_CNT) cnt_reg_q <= hwdata[15:0];
      if (wr_addr_q == `UEDMA_A_HW) hw_q <= hwdata[2:0];
    end
  end

  // transfer state; disabling stops with no end indication
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= UEDMA_OFF;
    end else if (usb_bus_reset || (cfg_wr && !hwdata[`UEDMA_CFG_EN])) begin
      st_q <= UEDMA_OFF;
    end else if (start) begin
      st_q <= UEDMA_ARMED;
    end else begin
      unique case (st_q)
        UEDMA_OFF: st_q <= UEDMA_OFF;
        UEDMA_DONE: st_q <= UEDMA_DONE;
        UEDMA_ARMED: begin
          if (eot_hit) st_q <= UEDMA_DONE;
          else if (can_req) st_q <= UEDMA_REQ;
        end
        UEDMA_REQ: begin
          if (eot_hit) st_q <= UEDMA_DONE;
          else if (word_done && burst_end) st_q <= UEDMA_ARMED;
        end
      endcase
    end
  end

  // request level follows the next state; pin gets the polarity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_act_q <= 1'b0;
      transfer_request_out <= 1'b0;
    end else begin
      req_act_q <= 1'b0;
      transfer_request_out <= !hw_q[`UEDMA_HW_REQHI];
      if (!usb_bus_reset && !cfg_wr && !eot_hit &&
          ((st_q == UEDMA_ARMED && can_req) ||
           (st_q == UEDMA_REQ && !(word_done && burst_end)))) begin
        req_act_q <= 1'b1;
        transfer_request_out <= hw_q[`UEDMA_HW_REQHI];
      end
    end
  end

  // words in the current burst, restarted with each request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) burst_q <= 3'h0;
    else if (st_q != UEDMA_REQ) burst_q <= 3'h0;
    else if (word_done) burst_q <= burst_q + 3'h1;
  end

  // byte counter loads on enable, steps by a word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_q <= `UEDMA_CNT_RST;
    else if (start) cnt_q <= (wr_addr_q == `UEDMA_A_CNT) ? hwdata[15:0] : cnt_reg_q;
    else if (word_done) cnt_q <= cnt_next;
  end

  // strobe and ack history for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_strobe_in;
      wr_prev_q <= wr_strobe_in;
      ack_prev_q <= ack_act;
    end
  end

  // out data drive only during ack with read strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_data_out <= 16'h0000;
      dma_data_oe <= 1'b0;
    end else begin
      dma_data_oe <= st_act && idx_ok && !ep_dir && ack_act && rd_strobe_in;
      if (ack_act && rd_strobe_in) dma_data_out <= buf_rdata;
    end
  end

  // buffer routing and access strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_ep_sel <= 4'h0;
      buf_rd <= 1'b0;
      buf_wr <= 1'b0;
      buf_wdata <= 16'h0000;
      buf_validate <= 1'b0;
    end else begin
      buf_ep_sel <= (ack_act && idx_ok) ? dma_ep : pio_ep_sel;
      buf_rd <= word_done && !ep_dir;
      buf_wr <= word_done && ep_dir;
      if (word_done && ep_dir) buf_wdata <= dma_data_in;
      buf_validate <= short_in_hit; // partial in buffer goes out short
    end
  end

  // end indication; a new end beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eot_pulse <= 1'b0;
      eot_flag_q <= 1'b0;
    end else begin
      eot_pulse <= eot_hit && !cfg_wr && !usb_bus_reset;
      if (eot_hit && !cfg_wr && !usb_bus_reset) eot_flag_q <= 1'b1;
      else if (wr_pend_q && wr_addr_q == `UEDMA_A_STAT && hwdata[`UEDMA_ST_EOT])
        eot_flag_q <= 1'b0;
    end
  end

  req_idle_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q == UEDMA_OFF || st_q == UEDMA_DONE) && !start |=> !req_act_q)
    else $error("request active while dma stopped");
  req_polarity_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $stable(hw_q) |-> ##1 transfer_request_out == (req_act_q ~^ $past(hw_q[1])))
    else $error("request pin polarity wrong");
  single_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    word_done && !cfg_q[3] |=> !req_act_q)
    else $error("single mode request held after word");
  burst_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == UEDMA_REQ && word_done && cfg_q[3] && burst_q < 3'h7 && !eot_hit &&
    !cfg_wr && !usb_bus_reset |=> req_act_q)
    else $error("burst request dropped early");
  oe_needs_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dma_data_oe |-> $past(ack_act && rd_strobe_in))
    else $error("data driven without ack and read");
  ack_drop_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ack_act |=> !dma_data_oe)
    else $error("data driven after ack dropped");
  ack_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_act && idx_ok |=> buf_ep_sel == $past(dma_ep))
    else $error("buffer not routed to dma endpoint");
  cnt_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start && wr_addr_q != 8'h04 |=> cnt_q == $past(cnt_reg_q))
    else $error("counter not loaded on enable");
  cnt_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cnt_hit && !cfg_wr && !usb_bus_reset |=> st_q == UEDMA_DONE ##1 !req_act_q)
    else $error("counter end did not stop dma");
  ack_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hw_q[0] && st_q != UEDMA_REQ |=> !req_act_q)
    else $error("request raised in ack-only mode");
  bad_index_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dma_idx < 4'h2 && $stable(cfg_q) |=> !req_act_q && !buf_rd && !buf_wr)
    else $error("control endpoint reached by dma");
  quiet_disable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_wr && !hwdata[0] |=> !eot_pulse && st_q == UEDMA_OFF)
    else $error("disable gave an end indication");
endmodule : uedma_top

// [uedma_dma_ctrl_model.sv]
// fly-by dma controller model facing the endpoint dma slave port
// assumes the bench sets budget, direction and end request by hierarchy
`timescale 1ns/100ps
module uedma_dma_ctrl_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic transfer_request_out,
  input wire logic req_hi,
  input wire logic ack_hi,
  input wire logic [15:0] fill_word,
  input wire logic [15:0] dma_data_out,
  input wire logic dma_data_oe,
  output logic transfer_ack_in,
  output logic end_of_transfer_in,
  output logic rd_strobe_in,
  output logic wr_strobe_in,
  output logic [15:0] dma_data_in
);
  logic ack_act;
  logic req_act;
  logic to_dev;
  logic eot_last;
  int budget;
  int run;
  int max_run;
  int bytes_left;
  int mem_addr;
  logic [15:0] got_q[$];
  logic [15:0] sent_q[$];
  // pin polarity applied here only, the loop thinks in active terms
  assign req_act = transfer_request_out ~^ req_hi;
  assign transfer_ack_in = ack_act ~^ ack_hi;
  // one ack per request; more words under it while the request holds
  initial begin
    ack_act = 1'b0;
    end_of_transfer_in = 1'b0;
    rd_strobe_in = 1'b0;
    wr_strobe_in = 1'b0;
    dma_data_in = 16'h0;
    to_dev = 1'b0;
    eot_last = 1'b0;
    budget = 0;
    max_run = 0;
    bytes_left = 0;
    mem_addr = 0;
    forever begin
      @(posedge hclk);
      if (hresetn && budget > 0 && req_act) begin
        ack_act <= 1'b1;
        run = 0;
        do begin
          @(posedge hclk);
          if (to_dev) begin
            dma_data_in <= fill_word;
            sent_q.push_back(fill_word);
            wr_strobe_in <= 1'b1;
            @(posedge hclk);
            wr_strobe_in <= 1'b0;
            dma_data_in <= ~dma_data_in; // inverted after the strobe: no stale value
          end else begin
            rd_strobe_in <= 1'b1;
            repeat (2) @(posedge hclk);
            got_q.push_back(dma_data_oe === 1'b1 ? dma_data_out : 16'hxxxx);
            rd_strobe_in <= 1'b0;
          end
          // end raised after the last word, while ack still stands
          end_of_transfer_in <= eot_last && budget == 1;
          budget--;
          run++;
          mem_addr += 2;
          bytes_left -= 2;
          @(posedge hclk);
          end_of_transfer_in <= 1'b0;
          repeat (2) @(posedge hclk);
        end while (req_act && budget > 0);
        ack_act <= 1'b0;
        if (run > max_run) max_run = run;
      end
    end
  end
endmodule : uedma_dma_ctrl_model

// [usb_device_endpoint_dma_bench.sv]
// self-checking bench for the endpoint dma slave port
// assumes the design files and the controller model are compiled first
`timescale 1ns/100ps
`include "uedma_defs.svh"
module usb_device_endpoint_dma_bench import uedma_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic req;
  logic ack;
  logic eot_in;
  logic rd_s;
  logic wr_s;
  logic [15:0] d_in;
  logic [15:0] d_out;
  logic d_oe;
  logic usb_bus_reset = 1'b0;
  logic [15:0] ep_packet_ready = 16'h0;
  logic buf_short_last;
  logic usb_eop = 1'b0;
  uedma_idx_t pio_ep_sel = 4'h0;
  logic [15:0] buf_rdata = 16'h0;
  uedma_idx_t buf_ep_sel;
  logic buf_rd;
  logic buf_wr;
  logic [15:0] buf_wdata;
  logic buf_validate;
  logic eot_pulse;
  logic [31:0] rs = 32'h955c;
  logic req_hi = 1'b1;
  logic ack_hi = 1'b1;
  logic ack_d = 1'b0;
  uedma_idx_t cur_ep = 4'h0;
  int short_at = 0;
  int n_rd = 0;
  int n_eot = 0;
  int n_val = 0;
  int req_seen = 0;
  int error_cnt = 0;
  int checks = 0;
  logic [15:0] exp_q[$];
  logic [15:0] wr_q[$];
  assign buf_short_last = (n_rd == short_at - 1);
  always #2.5 hclk = ~hclk;
  uedma_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .transfer_request_out(req), .transfer_ack_in(ack), .end_of_transfer_in(eot_in),
    .rd_strobe_in(rd_s), .wr_strobe_in(wr_s), .dma_data_in(d_in), .dma_data_out(d_out),
    .dma_data_oe(d_oe), .usb_bus_reset(usb_bus_reset), .ep_packet_ready(ep_packet_ready),
    .buf_short_last(buf_short_last), .usb_eop(usb_eop), .pio_ep_sel(pio_ep_sel),
    .buf_rdata(buf_rdata), .buf_ep_sel(buf_ep_sel), .buf_rd(buf_rd), .buf_wr(buf_wr),
    .buf_wdata(buf_wdata), .buf_validate(buf_validate), .eot_pulse(eot_pulse));
  uedma_dma_ctrl_model pm (.hclk(hclk), .hresetn(hresetn), .transfer_request_out(req),
    .req_hi(req_hi), .ack_hi(ack_hi), .fill_word(rs[15:0]), .dma_data_out(d_out),
    .dma_data_oe(d_oe), .transfer_ack_in(ack), .end_of_transfer_in(eot_in),
    .rd_strobe_in(rd_s), .wr_strobe_in(wr_s), .dma_data_in(d_in));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // end expected from the enabled end sources of this transfer
  function automatic logic exp_eot(input logic [1:0] epc, input logic [2:0] fl,
      input logic [15:0] cnt, input int nw, input logic [1:0] ext);
    logic done;
    done = nw > 0 && cnt <= 16'(2 * nw);
    return (fl[0] && done) || (fl[1] && epc == 2'b01 && done) || (ext[0] && nw > 0)
      || (fl[1] && epc == 2'b00 && short_at == nw && nw > 0) || (ext[1] && epc[1]);
  endfunction : exp_eot
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // one single ahb-lite transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) n = 100;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : ahb
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rchk
  // random stream, buffer side of the design and pin monitors
  always @(posedge hclk) begin
    rs <= xs(rs);
    pio_ep_sel <= rs[23:20];
    if (buf_rd) begin
      exp_q.push_back(buf_rdata);
      buf_rdata <= rs[31:16];
      n_rd++;
    end
    if (buf_wr) wr_q.push_back(buf_wdata);
    if (eot_pulse) n_eot++;
    if (buf_validate) n_val++;
    if (pm.req_act) req_seen++;
    if (pm.ack_act && ack_d) chk(buf_ep_sel, cur_ep);
    if (!pm.ack_act && !ack_d) chk(d_oe, 1'b0);
    ack_d <= pm.ack_act;
  end
  // configure, enable, let the model move nw words, then judge and disable
  task automatic xfer(input uedma_idx_t ep, input logic [1:0] epc, input logic [2:0] fl,
      input logic [15:0] cnt, input int nw, input logic [1:0] ext);
    int n;
    logic xe;
    int run;
    xe = exp_eot(epc, fl, cnt, nw, ext);
    run = nw == 0 ? 0 : !fl[2] ? 1 : nw > `UEDMA_BURST_BYTES / 2 ? `UEDMA_BURST_BYTES / 2 : nw;
    cur_ep = ep;
    exp_q.delete();
    wr_q.delete();
    pm.got_q.delete();
    pm.sent_q.delete();
    n_rd = 0;
    n_eot = 0;
    n_val = 0;
    req_seen = 0;
    pm.max_run = 0;
    pm.to_dev = epc[0];
    pm.eot_last = ext[0];
    pm.bytes_left = int'(cnt);
    wreg(`UEDMA_A_EP_BASE + {2'b00, ep, 2'b00}, {29'h0, 1'b1, epc});
    wreg(`UEDMA_A_CNT, {16'h0, cnt});
    ep_packet_ready[ep] <= 1'b1;
    wreg(`UEDMA_A_CFG, {24'h0, ep + 4'h1, fl, 1'b1});
    rchk(`UEDMA_A_REM, {16'h0, cnt});
    pm.budget = nw;
    n = 0;
    while ((pm.budget > 0 || pm.ack_act === 1'b1) && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 3000) begin
      error_cnt++;
      tally_and_finish();
    end
    usb_eop <= ext[1];
    @(posedge hclk);
    usb_eop <= 1'b0;
    repeat (8) @(posedge hclk);
    chk(n_eot, xe);
    chk(n_val, fl[1] && epc == 2'b01 && xe);
    chk(pm.max_run, run);
    rchk(`UEDMA_A_REM, {16'h0, cnt > 16'(2 * nw) ? cnt - 16'(2 * nw) : 16'h0});
    if (nw == 0) chk(req_seen, 0);
    if (xe) chk(pm.req_act, 1'b0);
    chk(epc[0] ? wr_q.size() : exp_q.size(), nw);
    foreach (pm.sent_q[i]) chk(wr_q[i], pm.sent_q[i]);
    foreach (pm.got_q[i]) chk(pm.got_q[i], exp_q[i]);
    wreg(`UEDMA_A_CFG, 32'h0);
    ep_packet_ready[ep] <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(pm.req_act, 1'b0);
    chk(n_eot, xe);
    rchk(`UEDMA_A_STAT, {30'h0, xe, 1'b0});
    wreg(`UEDMA_A_STAT, 32'h2);
  endtask : xfer
  // main sequence: reset values, refusals, random and corner transfers
  initial begin
    logic [31:0] r;
    int nw;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk(hresp, 1'b0);
    rchk(`UEDMA_A_HW, {29'h0, `UEDMA_HW_RST});
    rchk(`UEDMA_A_CFG, 32'h0);
    rchk(`UEDMA_A_CNT, 32'h0);
    wreg(`UEDMA_A_EP_BASE, 32'h0);
    rchk(`UEDMA_A_EP_BASE, {29'h0, `UEDMA_EP0_CFG});
    wreg(8'h20, 32'hffff_ffff);
    rchk(8'h20, 32'h0);
    xfer(4'h0, 2'b00, 3'b001, 16'h4, 0, 2'b00);
    wreg(`UEDMA_A_HW, 32'h7);
    xfer(4'h2, 2'b00, 3'b001, 16'h4, 0, 2'b00);
    wreg(`UEDMA_A_HW, 32'h6);
    for (int k = 0; k < 6; k++) begin
      r = rs;
      nw = int'(r[11:8] % 4'd10) + 1;
      xfer(uedma_idx_t'(r[3:0] % 4'd14 + 4'd1), {1'b0, r[4]}, {r[5], 2'b01},
        16'(2 * nw), nw, 2'b00);
    end
    wreg(`UEDMA_A_HW, 32'h0);
    req_hi <= 1'b0;
    ack_hi <= 1'b0;
    xfer(4'h5, 2'b01, 3'b101, 16'd20, 10, 2'b00);
    wreg(`UEDMA_A_HW, 32'h6);
    req_hi <= 1'b1;
    ack_hi <= 1'b1;
    xfer(4'h3, 2'b00, 3'b000, 16'h4, 3, 2'b00);
    short_at = 2;
    xfer(4'h7, 2'b00, 3'b010, 16'd100, 2, 2'b00);
    short_at = 0;
    xfer(4'h9, 2'b01, 3'b010, 16'h6, 3, 2'b00);
    xfer(4'h4, 2'b10, 3'b000, 16'd100, 2, 2'b10);
    xfer(4'h6, 2'b11, 3'b001, 16'h4, 2, 2'b00);
    xfer(4'h8, 2'b00, 3'b001, 16'd100, 2, 2'b01);
    usb_bus_reset <= 1'b1;
    @(posedge hclk);
    usb_bus_reset <= 1'b0;
    rchk(8'h60, 32'h0);
    rchk(`UEDMA_A_EP_BASE, {29'h0, `UEDMA_EP0_CFG});
    tally_and_finish();
  end
endmodule : usb_device_endpoint_dma_bench
